//--- pkg/recovery_map.svh
// Purpose: offsets, field positions, reset values and timer counts
// Assumes: included by its bare name from the package and the rtl files
// Notes: timer counts are in pclk cycles (250 MHz, 4 ns)
// What this block does
// - source-activity expiry in source-on sends ping
// - ping sent returns to swap source-on
// - ping failure goes to sink hard reset
// - sink-role request, or timeouts within the count limit, force hard reset
// - sink-role hard reset done enters swap recovery
// - received hard reset enters swap recovery
// - swap recovery timer expiry goes source default
// - source-role request, or timeout within the count limit, forces hard reset
// - detected hard reset turns supply off
// - supply off reported moves to sink default
// - start up, reset protocol, then bus check
// - bus check: voltage to caps, timeout to power
// - apply dead-battery level, then wait stream
// - bit stream seen to five volts, timer to unpower
// - apply safe five volts, then wait stop
// - stream stop to send caps, timer unpowers
// - apply safe zero, then supply discharge
// - source-off timer expiry returns to bus check
// - after dead-battery swap ignore source caps
`ifndef RECOVERY_MAP_SVH
`define RECOVERY_MAP_SVH
`define ADDR_W 12
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define LIMIT_OFS 12'h008
`define CTRL_ROLE_CP_BIT 0
`define CTRL_HR_REQ_BIT 1
`define CTRL_CLR_COUNT_BIT 2
`define STATUS_IGNORE_BIT 8
`define STATUS_COUNT_LSB 12
`define ROLE_CP_RESET 1'b1
`define HR_LIMIT_RESET 4'h2
`define COUNT_MAX 4'hf
`define TIMER_W 16
`define SOURCE_ACTIVITY_CYCLES 16'h03e8
`define SWAP_RECOVERY_CYCLES 16'h03e8
`define DB_DETECT_CYCLES 16'h03e8
`define BIT_STREAM_DETECT_CYCLES 16'h03e8
`define DEVICE_READY_CYCLES 16'h03e8
`define DB_SOURCE_OFF_CYCLES 16'h03e8
`endif

//--- pkg/recovery_pkg.sv
// Purpose: types shared by the recovery state machine and its timer
// Assumes: recovery_map.svh supplies the widths
// Notes: state codes are also visible in the status word
`include "recovery_map.svh"
package recovery_pkg;
  // policy states covered here; other_state stands for the rest of the engine
  typedef enum logic [4:0] {
    other_state = 5'h00, swap_source_on_state = 5'h01, swap_ping_state = 5'h02,
    sink_hard_reset_state = 5'h03, pc_sink_hard_reset_state = 5'h04,
    swap_recovery_state = 5'h05, source_to_default_state = 5'h06,
    cp_source_hard_reset_state = 5'h07, cp_source_to_off_state = 5'h08,
    sink_to_default_state = 5'h09, sink_startup_state = 5'h0a, bus_check_state = 5'h0b,
    wait_capabilities_state = 5'h0c, dead_battery_power_state = 5'h0d,
    wait_bit_stream_state = 5'h0e, apply_5v_state = 5'h0f,
    wait_bit_stream_stop_state = 5'h10, send_source_caps_state = 5'h11,
    unpower_state = 5'h12, supply_discharge_state = 5'h13
  } pe_state_t;
  // whole state of the main module
  typedef struct packed {
    pe_state_t state;
    logic role_cp;
    logic hr_pulse;
    logic [3:0] hr_count;
    logic [3:0] hr_limit;
    logic db_swapped;
    logic tx_ping;
    logic hr_send;
    logic prl_reset;
    logic nr_stop;
    logic supply_off;
    logic apply_db;
    logic apply_5v;
    logic apply_0v;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fsm_regs_t;
  // whole state of the shared timer
  typedef struct packed {
    logic [`TIMER_W-1:0] count;
    logic running;
    logic expire;
  } timer_regs_t;
endpackage

//--- rtl/down_timer.sv
// Purpose: one down-counting timer with a single-cycle expiry pulse
// Assumes: load value of zero simply stops the timer
// Notes: a load in the same cycle as expiry cancels the pulse
`timescale 1ns/10ps
`include "recovery_map.svh"
module down_timer (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic load, // reload strobe on state entry
  input wire logic [`TIMER_W-1:0] load_value, // cycles until expiry, zero stops
  output logic expire // one-cycle expiry pulse
);
  import recovery_pkg::*;
  timer_regs_t t_reg; // registered timer state
  timer_regs_t t_next; // next timer state

  // reload on entry, count down, pulse once at the end
  always_comb begin
    t_next = t_reg;
    t_next.expire = 1'b0;
    if (load) begin
      t_next.count = load_value;
      t_next.running = (load_value != '0);
    end else if (t_reg.running) begin
      if (t_reg.count == `TIMER_W'(1)) begin
        t_next.running = 1'b0;
        t_next.expire = 1'b1;
      end else begin
        t_next.count = t_reg.count - `TIMER_W'(1);
      end
    end
  end

  // register the timer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign expire = t_reg.expire;

  chk_expire_single: assert property (@(posedge pclk) disable iff (!presetn)
    expire |=> !expire) else $error("timer expiry lasted more than one cycle");
endmodule

//--- rtl/dual_role_recovery_fsm.sv
// Purpose: dual-role keep-alive ping, hard-reset recovery, dead-battery start
// Assumes: all event inputs come from logic on pclk and are one-cycle pulses
// Notes: registers over APB; every output comes from the state flop
`timescale 1ns/10ps
`include "recovery_map.svh"
module dual_role_recovery_fsm #(
  parameter logic [15:0] SOURCE_ACTIVITY_CYCLES = `SOURCE_ACTIVITY_CYCLES,
  parameter logic [15:0] SWAP_RECOVERY_CYCLES = `SWAP_RECOVERY_CYCLES,
  parameter logic [15:0] DB_DETECT_CYCLES = `DB_DETECT_CYCLES,
  parameter logic [15:0] BIT_STREAM_DETECT_CYCLES = `BIT_STREAM_DETECT_CYCLES,
  parameter logic [15:0] DEVICE_READY_CYCLES = `DEVICE_READY_CYCLES,
  parameter logic [15:0] DB_SOURCE_OFF_CYCLES = `DB_SOURCE_OFF_CYCLES
) (
  input wire logic pclk, // clock, 250 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [`ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic port_is_source, // current power role is source
  input wire logic enter_source_on, // swap engine enters source-on
  input wire logic handoff_done, // outer engine took over
  input wire logic ping_sent, // protocol: ping sent
  input wire logic ping_failed, // protocol: ping failed after retries
  input wire logic hard_reset_rx, // hard reset signaling received
  input wire logic hard_reset_done, // own hard reset complete
  input wire logic hr_dpm_req, // policy manager asks for hard reset
  input wire logic wait_cap_expired, // wait capabilities timer expiry
  input wire logic sink_activity_expired, // sink activity timer expiry
  input wire logic supply_transition_expired, // supply transition timer expiry
  input wire logic no_response_expired, // no response timer expiry
  input wire logic prl_reset_done, // protocol layer reset finished
  input wire logic bus_above_zero, // bus above safe zero level
  input wire logic supply_off_done, // supply switched off
  input wire logic db_level_present, // dead battery level on bus
  input wire logic five_volt_present, // safe five volt level on bus
  input wire logic zero_applied, // safe zero level applied
  input wire logic bit_stream_rx, // phy: bit stream received
  input wire logic bit_stream_stopped, // phy: bit stream stopped
  output logic tx_ping, // request ping transmit
  output logic hard_reset_send, // request hard reset signaling
  output logic prl_reset_req, // request protocol layer reset
  output logic no_response_stop, // stop the no response timer
  output logic supply_off_req, // ask to switch the supply off
  output logic apply_db_req, // ask for dead battery level
  output logic apply_5v_req, // ask for safe five volt level
  output logic apply_0v_req, // ask for safe zero level
  output logic ignore_source_caps, // drop received source capabilities
  output logic [4:0] state_code // current state
);
  import recovery_pkg::*;

  fsm_regs_t s_reg; // all registered state
  fsm_regs_t s_next; // next value of all state
  logic timer_load; // reload on every state entry
  logic [15:0] timer_value; // reload figure of the entered state
  logic timer_expire; // one-cycle expiry of the shared timer
  logic pc_sink_role; // provider/consumer acting as sink
  logic cp_source_role; // consumer/provider acting as source
  logic hr_request; // hard reset asked by software or manager
  logic budget_ok; // hard reset count within limit
  logic pc_trigger; // sink-role hard reset cause
  logic cp_trigger; // source-role hard reset cause
  logic setup_phase; // apb setup cycle
  logic access_done; // apb access completes this edge

  // role and cause decoding
  assign pc_sink_role = !s_reg.role_cp && !port_is_source;
  assign cp_source_role = s_reg.role_cp && port_is_source;
  assign hr_request = hr_dpm_req || s_reg.hr_pulse;
  assign budget_ok = (s_reg.hr_count <= s_reg.hr_limit);
  assign pc_trigger = pc_sink_role && (hr_request || (budget_ok &&
    (wait_cap_expired || sink_activity_expired || supply_transition_expired ||
    no_response_expired)));
  assign cp_trigger = cp_source_role && (hr_request ||
    (budget_ok && no_response_expired));
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && s_reg.pready;

  // address decode, used for the error answer; read data decodes paddr in its own case
  function automatic logic is_mapped(input logic [`ADDR_W-1:0] addr);
    is_mapped = (addr == `CTRL_OFS) || (addr == `STATUS_OFS) || (addr == `LIMIT_OFS);
  endfunction

  // reload figure per entered state; zero means no timer runs there
  function automatic logic [15:0] timer_reload(input pe_state_t st);
    case (st)
      swap_source_on_state: timer_reload = SOURCE_ACTIVITY_CYCLES;
      swap_recovery_state: timer_reload = SWAP_RECOVERY_CYCLES;
      bus_check_state: timer_reload = DB_DETECT_CYCLES;
      wait_bit_stream_state: timer_reload = BIT_STREAM_DETECT_CYCLES;
      wait_bit_stream_stop_state: timer_reload = DEVICE_READY_CYCLES;
      supply_discharge_state: timer_reload = DB_SOURCE_OFF_CYCLES;
      default: timer_reload = 16'h0000;
    endcase
  endfunction

  // the one timer serves whichever state is current
  assign timer_load = (s_next.state != s_reg.state);
  assign timer_value = timer_reload(s_next.state);

  down_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(timer_load),
    .load_value(timer_value),
    .expire(timer_expire)
  );

  // bus slave, transitions and entry actions
  always_comb begin
    s_next = s_reg;
    // one-cycle strobes fall back every cycle
    s_next.hr_pulse = 1'b0;
    s_next.tx_ping = 1'b0;
    s_next.hr_send = 1'b0;
    s_next.prl_reset = 1'b0;
    s_next.nr_stop = 1'b0;
    s_next.supply_off = 1'b0;
    s_next.apply_db = 1'b0;
    s_next.apply_5v = 1'b0;
    s_next.apply_0v = 1'b0;
    // ready in the first access cycle, data captured in setup
    s_next.pready = setup_phase;
    if (setup_phase) begin
      s_next.pslverr = !is_mapped(paddr);
      s_next.prdata = 32'h0000_0000;
      case (paddr)
        `CTRL_OFS: begin
          s_next.prdata[`CTRL_ROLE_CP_BIT] = s_reg.role_cp;
        end
        `STATUS_OFS: begin
          s_next.prdata[4:0] = s_reg.state;
          s_next.prdata[`STATUS_IGNORE_BIT] = s_reg.db_swapped;
          s_next.prdata[`STATUS_COUNT_LSB +: 4] = s_reg.hr_count;
        end
        `LIMIT_OFS: begin
          s_next.prdata[3:0] = s_reg.hr_limit;
        end
        default: begin
          s_next.prdata = 32'h0000_0000;
        end
      endcase
    end else if (!psel) begin
      s_next.pslverr = 1'b0;
    end
    // writes take effect at the completing edge only
    if (access_done && pwrite) begin
      case (paddr)
        `CTRL_OFS: begin
          s_next.role_cp = pwdata[`CTRL_ROLE_CP_BIT];
          s_next.hr_pulse = pwdata[`CTRL_HR_REQ_BIT];
          if (pwdata[`CTRL_CLR_COUNT_BIT]) begin
            s_next.hr_count = 4'h0;
          end
        end
        `LIMIT_OFS: begin
          s_next.hr_limit = pwdata[3:0];
        end
        default: begin
          s_next.hr_pulse = 1'b0;
        end
      endcase
    end
    // received hard reset first, own causes next, local moves last
    if (hard_reset_rx && pc_sink_role) begin
      s_next.state = swap_recovery_state;
    end else if (hard_reset_rx && cp_source_role) begin
      s_next.state = cp_source_to_off_state;
    end else if (pc_trigger && s_reg.state != pc_sink_hard_reset_state) begin
      s_next.state = pc_sink_hard_reset_state;
    end else if (cp_trigger && s_reg.state != cp_source_hard_reset_state) begin
      s_next.state = cp_source_hard_reset_state;
    end else begin
      case (s_reg.state)
        other_state: begin
          if (enter_source_on) begin
            s_next.state = swap_source_on_state;
          end
        end
        swap_source_on_state: begin
          if (timer_expire) begin
            s_next.state = swap_ping_state;
          end else if (handoff_done) begin
            s_next.state = other_state;
          end
        end
        swap_ping_state: begin
          if (ping_sent) begin
            s_next.state = swap_source_on_state;
          end else if (ping_failed) begin
            s_next.state = sink_hard_reset_state;
          end
        end
        pc_sink_hard_reset_state: begin
          if (hard_reset_done) begin
            s_next.state = swap_recovery_state;
          end
        end
        swap_recovery_state: begin
          if (timer_expire) begin
            s_next.state = source_to_default_state;
          end
        end
        cp_source_hard_reset_state: begin
          if (hard_reset_done) begin
            s_next.state = cp_source_to_off_state;
          end
        end
        cp_source_to_off_state: begin
          if (supply_off_done) begin
            s_next.state = sink_to_default_state;
          end
        end
        sink_startup_state: begin
          if (prl_reset_done) begin
            s_next.state = bus_check_state;
          end
        end
        bus_check_state: begin
          if (bus_above_zero) begin
            s_next.state = wait_capabilities_state;
          end else if (timer_expire) begin
            s_next.state = dead_battery_power_state;
          end
        end
        dead_battery_power_state: begin
          if (db_level_present) begin
            s_next.state = wait_bit_stream_state;
          end
        end
        wait_bit_stream_state: begin
          if (bit_stream_rx) begin
            s_next.state = apply_5v_state;
          end else if (timer_expire) begin
            s_next.state = unpower_state;
          end
        end
        apply_5v_state: begin
          if (five_volt_present) begin
            s_next.state = wait_bit_stream_stop_state;
          end
        end
        wait_bit_stream_stop_state: begin
          if (bit_stream_stopped) begin
            s_next.state = send_source_caps_state;
          end else if (timer_expire) begin
            s_next.state = unpower_state;
          end
        end
        unpower_state: begin
          if (zero_applied) begin
            s_next.state = supply_discharge_state;
          end
        end
        supply_discharge_state: begin
          if (timer_expire) begin
            s_next.state = bus_check_state;
          end
        end
        source_to_default_state, sink_to_default_state, wait_capabilities_state,
        send_source_caps_state, sink_hard_reset_state: begin
          // the outer engine continues from these states
          if (handoff_done) begin
            s_next.state = other_state;
          end
        end
        default: begin
          s_next.state = other_state;
        end
      endcase
    end
    // entry actions fire once, on the cycle the state is entered
    if (s_next.state != s_reg.state) begin
      case (s_next.state)
        swap_ping_state: begin
          s_next.tx_ping = 1'b1;
        end
        pc_sink_hard_reset_state, cp_source_hard_reset_state,
        sink_hard_reset_state: begin
          s_next.hr_send = 1'b1;
          // counting wins over a software clear in the same cycle, unless the count already sits at COUNT_MAX
          if (s_reg.hr_count != `COUNT_MAX) begin
            s_next.hr_count = s_reg.hr_count + 4'h1;
          end
        end
        cp_source_to_off_state: begin
          s_next.supply_off = 1'b1;
        end
        sink_startup_state: begin
          s_next.prl_reset = 1'b1;
        end
        bus_check_state: begin
          s_next.nr_stop = 1'b1;
        end
        dead_battery_power_state: begin
          s_next.apply_db = 1'b1;
        end
        apply_5v_state: begin
          s_next.apply_5v = 1'b1;
        end
        unpower_state: begin
          s_next.apply_0v = 1'b1;
        end
        send_source_caps_state: begin
          s_next.db_swapped = 1'b1;
        end
        wait_capabilities_state: begin
          s_next.db_swapped = 1'b0;
        end
        default: begin
          s_next.db_swapped = s_next.db_swapped;
        end
      endcase
    end
  end

  // register all state; startup asks for a protocol reset right away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.state <= sink_startup_state;
      s_reg.prl_reset <= 1'b1;
      s_reg.role_cp <= `ROLE_CP_RESET;
      s_reg.hr_limit <= `HR_LIMIT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flop
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign tx_ping = s_reg.tx_ping;
  assign hard_reset_send = s_reg.hr_send;
  assign prl_reset_req = s_reg.prl_reset;
  assign no_response_stop = s_reg.nr_stop;
  assign supply_off_req = s_reg.supply_off;
  assign apply_db_req = s_reg.apply_db;
  assign apply_5v_req = s_reg.apply_5v;
  assign apply_0v_req = s_reg.apply_0v;
  assign ignore_source_caps = s_reg.db_swapped;
  assign state_code = s_reg.state;

  chk_ping_on_expiry: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.state == swap_source_on_state && timer_expire && !hard_reset_rx &&
    !pc_trigger && !cp_trigger |=> s_reg.state == swap_ping_state && tx_ping)
    else $error("no ping after source activity expiry");

  chk_ping_return: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.state == swap_ping_state && ping_sent && !hard_reset_rx &&
    !pc_trigger && !cp_trigger |=> s_reg.state == swap_source_on_state)
    else $error("ping sent did not return to source on");

  chk_ping_fail: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.state == swap_ping_state && ping_failed && !ping_sent && !hard_reset_rx &&
    !pc_trigger && !cp_trigger |=> s_reg.state == sink_hard_reset_state && hard_reset_send)
    else $error("ping failure did not start sink hard reset");

  chk_sink_trigger: assert property (@(posedge pclk) disable iff (!presetn)
    pc_trigger && !hard_reset_rx && s_reg.state != pc_sink_hard_reset_state
    |=> s_reg.state == pc_sink_hard_reset_state && hard_reset_send)
    else $error("sink role hard reset cause ignored");

  chk_rx_recovery: assert property (@(posedge pclk) disable iff (!presetn)
    hard_reset_rx && pc_sink_role |=> s_reg.state == swap_recovery_state)
    else $error("received hard reset did not enter swap recovery");

  chk_recovery_out: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.state == swap_recovery_state && $past(s_reg.state) != swap_recovery_state
    |-> !timer_expire ##1 !timer_expire)
    else $error("swap recovery timer expired too early");

  chk_off_request: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.state == cp_source_to_off_state && $past(s_reg.state) != cp_source_to_off_state
    |-> supply_off_req) else $error("supply off not requested on entry");

  chk_bus_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.state == bus_check_state && $past(s_reg.state) != bus_check_state
    |-> no_response_stop) else $error("no response timer not stopped");

  chk_caps_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.state == send_source_caps_state |-> ignore_source_caps)
    else $error("source caps not ignored after dead battery start");

  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");
endmodule

//--- verification/far_side_model.sv
// Purpose: far side model: policy manager and protocol layer answers
// Assumes: one request at a time, answered after 1 to 3 cycles
// Notes: ping_bad makes the next ping go unacknowledged after retries
`timescale 1ns/10ps
module far_side_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic [5:0] req, // prl, off, db, 5v, 0v, ping requests
  input wire logic ping_bad, // next ping fails
  output logic [6:0] ans // prl, off, db, 5v, 0v done, ping sent, ping failed
);
  logic [5:0] pend; // request waiting for its answer
  logic [1:0] cnt; // cycles left before answering
  // answers pulse one cycle; bus levels hold until safe zero is applied
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ans <= '0;
      pend <= '0;
      cnt <= '0;
    end else begin
      {ans[6:4], ans[1:0]} <= '0;
      if (|req) begin
        pend <= req;
        cnt <= 2'($urandom_range(1, 3));
      end else if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
        if (cnt == 2'h1) begin
          ans[1:0] <= pend[1:0];
          ans[4] <= pend[4];
          ans[5] <= pend[5] & !ping_bad;
          ans[6] <= pend[5] & ping_bad;
          if (pend[2]) ans[2] <= 1'h1;
          if (pend[3]) ans[3] <= 1'h1;
          if (pend[4]) ans[3:2] <= 2'h0;
        end
      end
    end
  end
endmodule

//--- verification/tb_dual_role_recovery_fsm.sv
// Purpose: self-checking bench for the recovery state machine
// Assumes: all timers shortened to 4 cycles
// Notes: events are one-cycle pulses from the ev vector
`timescale 1ns/10ps
module tb_dual_role_recovery_fsm;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, src, ping_bad, bus_hi, er;
  logic [11:0] paddr; // apb address
  logic [31:0] pwdata, prdata, rd, rv; // apb data, random limit word
  logic [10:0] ev; // event pulses
  logic [5:0] req; // requests to far side
  logic [6:0] ans; // far side answers
  logic ign, hrs, nrs; // caps ignore, hard reset send, no response stop
  logic [4:0] st; // state code
  int fail_count, checks, i, k;
  dual_role_recovery_fsm #(.SOURCE_ACTIVITY_CYCLES(16'h4), .SWAP_RECOVERY_CYCLES(16'h4),
    .DB_DETECT_CYCLES(16'h4), .BIT_STREAM_DETECT_CYCLES(16'h4),
    .DEVICE_READY_CYCLES(16'h4), .DB_SOURCE_OFF_CYCLES(16'h4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_is_source(src), .enter_source_on(ev[6]), .handoff_done(ev[7]),
    .ping_sent(ans[5]), .ping_failed(ans[6]), .hard_reset_rx(ev[5]),
    .hard_reset_done(ev[8]), .hr_dpm_req(ev[4]), .wait_cap_expired(ev[0]),
    .sink_activity_expired(ev[1]), .supply_transition_expired(ev[2]),
    .no_response_expired(ev[3]), .prl_reset_done(ans[0]), .bus_above_zero(bus_hi),
    .supply_off_done(ans[1]), .db_level_present(ans[2]), .five_volt_present(ans[3]),
    .zero_applied(ans[4]), .bit_stream_rx(ev[9]), .bit_stream_stopped(ev[10]),
    .tx_ping(req[5]), .hard_reset_send(hrs), .prl_reset_req(req[0]), .no_response_stop(nrs),
    .supply_off_req(req[1]), .apply_db_req(req[2]), .apply_5v_req(req[3]),
    .apply_0v_req(req[4]), .ignore_source_caps(ign), .state_code(st));
  far_side_model far (.pclk(pclk), .presetn(presetn), .req(req), .ping_bad(ping_bad),
    .ans(ans));
  // free-running 4 ns clock
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // wait a bounded time for a state, then compare
  task automatic wst(input logic [4:0] s);
    int n;
    n = 0;
    while (st !== s && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    cmp({27'h0, st}, {27'h0, s});
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'h1;
    @(posedge pclk);
    ev[b] <= 1'h0;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd <= prdata;
    er <= pslverr;
    {psel, penable} <= 2'h0;
    #1;
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    void'($urandom(10994));
    {presetn, psel, penable, pwrite, paddr, pwdata, ev, src, ping_bad, bus_hi} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    cmp(rd, 32'h1);
    apb(1'h0, 12'h008, 32'h0);
    cmp(rd, 32'h2);
    apb(1'h0, 12'hffc, 32'h0);
    cmp({31'h0, er}, 32'h1);
    cmp(rd, 32'h0);
    rv = $urandom;
    apb(1'h1, 12'h008, rv);
    apb(1'h0, 12'h008, 32'h0);
    cmp(rd, {28'h0, rv[3:0]});
    apb(1'h1, 12'h008, 32'h2);
    wst(5'h0b);
    for (k = 0; k < 3; k++) begin
      wst(5'h0d);
      wst(5'h0e);
      if (k > 0) begin
        pulse(9);
        wst(5'h0f);
        wst(5'h10);
      end
      if (k == 2) begin
        pulse(10);
        wst(5'h11);
      end else begin
        wst(5'h12);
        wst(5'h13);
        wst(5'h0b);
        cmp({31'h0, nrs}, 32'h1);
      end
    end
    cmp({31'h0, ign}, 32'h1);
    pulse(7);
    pulse(6);
    wst(5'h02);
    cmp({31'h0, req[5]}, 32'h1);
    wst(5'h01);
    ping_bad <= 1'h1;
    wst(5'h02);
    wst(5'h03);
    cmp({31'h0, hrs}, 32'h1);
    apb(1'h0, 12'h004, 32'h0);
    cmp(rd, 32'h1103);
    pulse(7);
    for (i = 0; i < 6; i++) begin
      apb(1'h1, 12'h000, 32'h4);
      pulse(i);
      if (i < 5) wst(5'h04);
      if (i < 5) pulse(8);
      wst(5'h05);
      wst(5'h06);
      pulse(7);
    end
    // software hard reset request, then a received hard reset mid reset
    apb(1'h1, 12'h000, 32'h2);
    wst(5'h04);
    pulse(5);
    wst(5'h05);
    wst(5'h06);
    pulse(7);
    src <= 1'h1;
    apb(1'h1, 12'h000, 32'h5);
    for (i = 3; i < 6; i++) begin
      pulse(i);
      if (i < 5) wst(5'h07);
      if (i < 5) pulse(8);
      wst(5'h08);
      wst(5'h09);
      pulse(7);
    end
    apb(1'h1, 12'h008, 32'h0);
    pulse(3);
    repeat (3) @(posedge pclk);
    cmp({27'h0, st}, 32'h0);
    presetn <= 1'h0;
    bus_hi <= 1'h1;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    wst(5'h0c);
    wrap_up();
  end
endmodule
